/* File: common/dhrs_regs.vh */
// timing constants for the display hardware reset sequencer
`ifndef DHRS_REGS_VH
`define DHRS_REGS_VH
`define DHRS_CLK_NS 100
`define DHRS_SPIKE_REJECT_NS 5000
`define DHRS_RESET_ACCEPT_NS 9000
`define DHRS_RELOAD_START_MS 5
`define DHRS_SETTLE_SHORT_MS 5
`define DHRS_SETTLE_LONG_MS 120
`define DHRS_NS_PER_MS 1000000
// load gives up waiting for the storage after this many cycles
`define DHRS_LOAD_TIMEOUT_CYC 16
// cycles; least times round up, longest times round down
`define DHRS_SPIKE_REJECT_CYC ((`DHRS_SPIKE_REJECT_NS + `DHRS_CLK_NS - 1) / `DHRS_CLK_NS)
`define DHRS_RESET_ACCEPT_CYC (`DHRS_RESET_ACCEPT_NS / `DHRS_CLK_NS)
`define DHRS_SETTLE_SHORT_CYC (`DHRS_SETTLE_SHORT_MS * `DHRS_NS_PER_MS / `DHRS_CLK_NS)
`define DHRS_SETTLE_LONG_CYC (`DHRS_SETTLE_LONG_MS * `DHRS_NS_PER_MS / `DHRS_CLK_NS)
`endif

/* File: rtl/dhrs_top.v */
// display hardware reset sequencer: spike filter, blanking and settings reload
//
// Summary of operation
// (RULE1) reject lows under 5us, reset beyond 9us
// (RULE2) reload settings, 5ms sleep-in, 120ms sleep-out
// (RULE3) reload every release, starting within 5ms
// (RULE4) blank during reset, then default condition
// (RULE5) brief highs inside valid reset rejected
// (RULE6) host waits 5ms before commands
// (RULE7) host waits 120ms before sleep-out
// (RULE8) host holds reset low long enough
`timescale 1ns/10ps
`include "dhrs_regs.vh"
module dhrs_top #(
   parameter FILT_CYC = `DHRS_RESET_ACCEPT_CYC,
   parameter SHORT_CYC = `DHRS_SETTLE_SHORT_CYC,
   parameter LONG_CYC = `DHRS_SETTLE_LONG_CYC,
   parameter LOAD_CYC = `DHRS_LOAD_TIMEOUT_CYC
) (
   // clock and power-on reset
   input wire REF_CLK,
   input wire RST_N,
   // reset line from host
   input wire HW_RESET_N,
   // current sleep state of the controller
   input wire SLEEP_OUT,
   // reload of settings from non-volatile storage
   output reg RELOAD_REQ,
   input wire RELOAD_DONE,
   // state shown to the rest of the controller
   output reg CORE_RESET_N,
   output reg BLANK,
   output reg READY
);
   // sequencer states
   localparam ST_IDLE = 3'H0;
   localparam ST_HELD = 3'H1;
   localparam ST_LOAD = 3'H2;
   localparam ST_SETTLE = 3'H3;
   // counter width, enough for the sleep-out settle count
   localparam CW = 32;
   // compare points; counts end exactly on their cycle, except the load timeout, which ends one cycle later
   localparam [CW-1:0] FILT_LAST = FILT_CYC - 1;
   localparam [CW-1:0] LOAD_END = LOAD_CYC;
   localparam [CW-1:0] SHORT_LAST = SHORT_CYC - 1;
   localparam [CW-1:0] LONG_LAST = LONG_CYC - 1;

   // sequencer state and counters
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [CW-1:0] low_cnt_q;
   reg [CW-1:0] low_cnt_d;
   reg [CW-1:0] high_cnt_q;
   reg [CW-1:0] high_cnt_d;
   reg [CW-1:0] settle_q;
   reg [CW-1:0] settle_d;
   reg [CW-1:0] limit_q;
   reg [CW-1:0] limit_d;
   reg sleep_out_q;
   reg sleep_out_d;
   // next values of the registered outputs
   reg reload_req_d;
   reg core_reset_n_d;
   reg blank_d;
   reg ready_d;

   // filter and phase decisions
   wire line_low;
   wire low_taken;
   wire high_taken;
   wire enter_held;
   wire reload_start;
   wire load_end;
   wire settle_end;

   assign line_low = ~HW_RESET_N;
   // a level counts only after FILT_CYC consecutive samples
   assign low_taken = line_low && (low_cnt_q >= FILT_LAST); // [RULE1]
   assign high_taken = !line_low && (high_cnt_q >= FILT_LAST); // [RULE5]
   // a genuine low restarts the sequence from any phase but the held one
   assign enter_held = low_taken &&
      (state_q == ST_IDLE || state_q == ST_LOAD || state_q == ST_SETTLE); // [RULE1]
   assign reload_start = high_taken && (state_q == ST_HELD); // [RULE3]
   assign load_end = RELOAD_DONE || (settle_q >= LOAD_END); // [RULE2]
   assign settle_end = (settle_q >= limit_q); // [RULE4]

   // consecutive-level counters, saturating at the accept point
   always @* begin
      low_cnt_d = {CW{1'B0}};
      high_cnt_d = {CW{1'B0}};
      if (line_low) begin
         if (low_cnt_q < FILT_LAST) begin
            low_cnt_d = low_cnt_q + 1'B1;
         end else begin
            low_cnt_d = low_cnt_q;
         end
      end else begin
         if (high_cnt_q < FILT_LAST) begin
            high_cnt_d = high_cnt_q + 1'B1;
         end else begin
            high_cnt_d = high_cnt_q;
         end
      end
   end

   // phase sequencing
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (low_taken) begin
               state_d = ST_HELD;
            end
         end
         ST_HELD: begin
            if (high_taken) begin
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // short lows here are spikes and leave the load running
            if (low_taken) begin
               state_d = ST_HELD;
            end else if (load_end) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (low_taken) begin
               state_d = ST_HELD;
            end else if (settle_end) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // settle timing, counted from the reload start and including the load
   always @* begin
      settle_d = settle_q;
      limit_d = limit_q;
      sleep_out_d = sleep_out_q;
      if (enter_held) begin
         sleep_out_d = SLEEP_OUT;
      end
      if (reload_start) begin
         settle_d = {CW{1'B0}};
         if (sleep_out_q) begin
            limit_d = LONG_LAST; // [RULE2]
         end else begin
            limit_d = SHORT_LAST; // [RULE2]
         end
      end else if (state_q == ST_LOAD || state_q == ST_SETTLE) begin
         settle_d = settle_q + 1'B1;
      end
   end

   // registered outputs hold their level between events, except RELOAD_REQ, which pulses for one cycle
   always @* begin
      reload_req_d = reload_start; // [RULE3]
      core_reset_n_d = CORE_RESET_N;
      blank_d = BLANK;
      ready_d = READY;
      // idle reports ready, also before the first reset
      if (state_q == ST_IDLE) begin
         ready_d = 1'B1;
      end
      if (enter_held) begin
         core_reset_n_d = 1'B0;
         blank_d = 1'B1; // [RULE4]
         ready_d = 1'B0;
      end else if (state_q == ST_LOAD && load_end) begin
         core_reset_n_d = 1'B1; // [RULE2]
      end else if (state_q == ST_SETTLE && settle_end) begin
         blank_d = 1'B0; // [RULE4]
         ready_d = 1'B1; // [RULE2]
      end
   end

   // filter counters and phase
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         low_cnt_q <= {CW{1'B0}};
         high_cnt_q <= {CW{1'B0}};
      end else begin
         state_q <= state_d;
         low_cnt_q <= low_cnt_d;
         high_cnt_q <= high_cnt_d;
      end
   end

   // settle timing and captured sleep state
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         settle_q <= {CW{1'B0}};
         limit_q <= {CW{1'B0}};
         sleep_out_q <= 1'B0;
      end else begin
         settle_q <= settle_d;
         limit_q <= limit_d;
         sleep_out_q <= sleep_out_d;
      end
   end

   // outputs come straight from flip-flops
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RELOAD_REQ <= 1'B0;
         CORE_RESET_N <= 1'B0;
         BLANK <= 1'B1;
         READY <= 1'B0;
      end else begin
         RELOAD_REQ <= reload_req_d;
         CORE_RESET_N <= core_reset_n_d;
         BLANK <= blank_d;
         READY <= ready_d;
      end
   end

endmodule // dhrs_top

/* File: tb/dhrs_host.sv */
// host model driving the display reset line
`timescale 1ns/10ps
module dhrs_host (
   // clock and reset line
   input wire clk,
   output reg hw_reset_n
);
   initial hw_reset_n = 1'b1;
   // level changes only at falling edges
   task drive(input bit lvl, input int n);
      hw_reset_n = lvl;
      repeat (n) @(negedge clk);
   endtask
endmodule // dhrs_host

/* File: tb/dhrs_assertions.sv */
// assertions for the display reset sequencer
`timescale 1ns/10ps
module dhrs_assertions #(parameter FILT_CYC = 4, parameter LONG_CYC = 200) (
   // top ports
   input wire REF_CLK,
   input wire RST_N,
   input wire HW_RESET_N,
   input wire RELOAD_REQ,
   input wire CORE_RESET_N,
   input wire BLANK,
   input wire READY
);
   localparam int LL = LONG_CYC + 2;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   a_spike_reject: assert property ($fell(CORE_RESET_N) |-> !$past(HW_RESET_N, FILT_CYC - 1))
      else $error("reset taken without a long low");
   a_blank_held: assert property ($fell(CORE_RESET_N) |-> (BLANK && !READY) [*8])
      else $error("panel not blanked during reset");
   a_reload_pulse: assert property ($rose(RELOAD_REQ) |=> !RELOAD_REQ && BLANK)
      else $error("reload request not one cycle");
   a_reload_release: assert property ($rose(RELOAD_REQ) |->
      $past(HW_RESET_N) && $past(HW_RESET_N, FILT_CYC))
      else $error("reload while line low");
   a_settle_bound: assert property ($rose(RELOAD_REQ) |-> ##[1:LL] (READY && !BLANK))
      else $error("settle too long");
   a_default_state: assert property ($fell(BLANK) |-> READY && CORE_RESET_N)
      else $error("unblanked outside default state");
endmodule // dhrs_assertions

/* File: tb/tb_dhrs_top.sv */
// self-checking bench for the display reset sequencer
`timescale 1ns/10ps
module tb_dhrs_top;
   localparam int S = 50, L = 200;
   logic clk = 0, rst_n = 0, sleep = 0, done = 0, rdy_q = 0;
   wire hw_n, req, core_n, blank, ready;
   int fail_count = 0, total_checks = 0, cnt = 0, lim = 0;
   int exp_q[$];
   dhrs_host host_u (.clk(clk), .hw_reset_n(hw_n));
   dhrs_top #(.FILT_CYC(4), .SHORT_CYC(S), .LONG_CYC(L), .LOAD_CYC(4)) dut_u (.REF_CLK(clk),
      .RST_N(rst_n), .HW_RESET_N(hw_n), .SLEEP_OUT(sleep), .RELOAD_REQ(req),
      .RELOAD_DONE(done), .CORE_RESET_N(core_n), .BLANK(blank), .READY(ready));
   initial forever #50 clk = ~clk;
   task check(input bit ok, input string msg);
      total_checks++;
      if (!ok) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task conclude;
      $display("checks %0d, failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // monitor: reload takes a note, readiness compares against it
   always @(negedge clk) begin
      rdy_q <= ready;
      cnt <= (req === 1'b1) ? 0 : cnt + 1;
      if (req === 1'b1) check(exp_q.size() > 0, "unexpected reload");
      if (req === 1'b1 && exp_q.size() > 0) lim = exp_q.pop_front();
      if (ready === 1'b1 && rdy_q === 1'b0 && lim > 0) begin
         check(cnt <= lim + 2 && cnt + 5 >= lim && core_n === 1'b1 && blank === 1'b0, "settle");
         lim = 0;
      end
   end
   initial begin
      void'($urandom(30));
      repeat (2) @(negedge clk);
      rst_n = 1;
      for (int i = 0; i < 4; i++) begin
         sleep = i[0];
         done = 1'($urandom);
         host_u.drive(0, 1 + $urandom % 3);
         host_u.drive(1, 10);
         exp_q.push_back(sleep ? L : S);
         host_u.drive(0, 6 + $urandom % 4);
         host_u.drive(1, 2);
         host_u.drive(0, 6);
         host_u.drive(1, 20);
         host_u.drive(0, 2);
         host_u.drive(1, 1);
         for (int k = 0; k < L + 40 && ready !== 1'b1; k++) @(negedge clk);
         host_u.drive(1, 5);
         check(exp_q.size() == 0 && ready === 1'b1, "sequence incomplete");
         $display("test %0d done", i);
      end
      conclude;
   end
   initial begin
      #400000;
      fail_count++;
      conclude;
   end
endmodule // tb_dhrs_top
bind dhrs_top dhrs_assertions #(.FILT_CYC(FILT_CYC), .LONG_CYC(LONG_CYC)) chk_u (.REF_CLK(REF_CLK),
   .RST_N(RST_N), .HW_RESET_N(HW_RESET_N), .RELOAD_REQ(RELOAD_REQ),
   .CORE_RESET_N(CORE_RESET_N), .BLANK(BLANK), .READY(READY));
